// ==== inc/phy_status_pkg.sv ====
// Contract
// - MII mode drives carrier sense high while the medium is busy, low when idle.
// - RMII mode drives one output merging carrier and receive data valid.
// - SNI mode drives carrier sense while busy; controller frames receive bit by it.
// - MII half duplex raises collision when transmit and receive overlap.
// - 10 Mbps MII half duplex with heartbeat pulses collision for about 1 us after transmit ends.
// - Full duplex holds collision low and gives no heartbeat pulse.
// - SNI half duplex raises collision when transmit and receive overlap.
// - MII mode drives the system clock output at 25 MHz from the reference input.
// - RMII mode drives the system clock output at 50 MHz.
package phy_status_pkg;

    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;

    localparam int CTRL_FULL_DUPLEX_BIT = 0;
    localparam int CTRL_SPEED_100_BIT = 1;
    localparam int CTRL_HEARTBEAT_BIT = 2;
    localparam logic CTRL_FULL_DUPLEX_RST = 1'b0;
    localparam logic CTRL_SPEED_100_RST = 1'b1;
    localparam logic CTRL_HEARTBEAT_RST = 1'b1;

    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_MODE_MSB = 1;
    localparam int STAT_CARRIER_BIT = 2;
    localparam int STAT_COLLISION_BIT = 3;
    localparam int STAT_HEARTBEAT_BIT = 4;
    localparam int STAT_MODE_VALID_BIT = 5;

    localparam int PCLK_PERIOD_NS = 8;
    localparam int HEARTBEAT_NS = 1000;
    localparam int HEARTBEAT_CYCLES = HEARTBEAT_NS / PCLK_PERIOD_NS;
    localparam int HB_CNT_W = 7;

    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        MODE_MII,
        MODE_RMII,
        MODE_SNI
    } if_mode_t;

    typedef struct packed {
        logic full_duplex;
        logic speed_100;
        logic heartbeat_en;
    } ctrl_t;

    typedef struct packed {
        logic ref_clk;
        logic tx_en;
        logic strap_rmii;
        logic strap_sni;
    } pin_in_t;

endpackage

// ==== rtl/heartbeat_timer.sv ====
`timescale 1ns/1ps
module heartbeat_timer
    import phy_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic busy
);

    logic [HB_CNT_W-1:0] cnt;
    logic [HB_CNT_W-1:0] next_cnt;

    // One-shot of about 1 us
    always_comb begin
        next_cnt = cnt;
        if (start) begin
            next_cnt = HB_CNT_W'(HEARTBEAT_CYCLES);
        end else if (cnt != '0) begin
            next_cnt = cnt - HB_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign busy = (cnt != '0);

    property p_hb_length;
        @(posedge pclk) disable iff (!presetn)
        start |=> (cnt == HB_CNT_W'(HEARTBEAT_CYCLES));
    endproperty
    a_hb_length: assert property (p_hb_length) else $error("Heartbeat load wrong");

    property p_hb_step;
        @(posedge pclk) disable iff (!presetn)
        (busy && !start) |=> (cnt == $past(cnt) - HB_CNT_W'(1));
    endproperty
    a_hb_step: assert property (p_hb_step) else $error("Heartbeat count skipped");

    property p_hb_end;
        @(posedge pclk) disable iff (!presetn)
        (cnt == HB_CNT_W'(1) && !start) |=> !busy;
    endproperty
    a_hb_end: assert property (p_hb_end) else $error("Heartbeat did not end");

endmodule

// ==== rtl/phy_mac_status.sv ====
`timescale 1ns/1ps
module phy_mac_status
    import phy_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic medium_busy,
    input wire logic rx_data_valid,
    input wire logic tx_enable,
    input wire logic reference_clock_input,
    input wire logic strap_rmii,
    input wire logic strap_sni,
    output logic carrier_sense,
    output logic collision,
    output logic system_clock_output
);

    // Pin synchronisers
    pin_in_t pin_meta;
    pin_in_t pin_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= '{ref_clk: reference_clock_input, tx_en: tx_enable,
                          strap_rmii: strap_rmii, strap_sni: strap_sni};
            pin_sync <= pin_meta;
        end
    end

    // Strap capture after reset release
    if_mode_t mode;
    if_mode_t next_mode;
    logic mode_valid;
    logic next_mode_valid;
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;

    always_comb begin
        next_mode = mode;
        next_mode_valid = mode_valid;
        next_strap_cnt = strap_cnt;
        if (!mode_valid) begin
            if (strap_cnt == STRAP_SETTLE) begin
                next_mode_valid = 1'b1;
                if (pin_sync.strap_rmii) begin
                    next_mode = MODE_RMII;
                end else if (pin_sync.strap_sni) begin
                    next_mode = MODE_SNI;
                end else begin
                    next_mode = MODE_MII;
                end
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_MII;
            mode_valid <= 1'b0;
            strap_cnt <= '0;
        end else begin
            mode <= next_mode;
            mode_valid <= next_mode_valid;
            strap_cnt <= next_strap_cnt;
        end
    end

    // Register file
    ctrl_t ctrl;
    ctrl_t next_ctrl;
    logic [31:0] next_prdata;
    logic hb_busy;
    logic addr_ok;

    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        next_ctrl = ctrl;
        next_prdata = prdata;
        if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            next_ctrl.full_duplex = pwdata[CTRL_FULL_DUPLEX_BIT];
            next_ctrl.speed_100 = pwdata[CTRL_SPEED_100_BIT];
            next_ctrl.heartbeat_en = pwdata[CTRL_HEARTBEAT_BIT];
        end
        if (psel && !penable) begin
            next_prdata = '0;
            if (paddr == ADDR_CTRL) begin
                next_prdata[CTRL_FULL_DUPLEX_BIT] = ctrl.full_duplex;
                next_prdata[CTRL_SPEED_100_BIT] = ctrl.speed_100;
                next_prdata[CTRL_HEARTBEAT_BIT] = ctrl.heartbeat_en;
            end else if (paddr == ADDR_STATUS) begin
                next_prdata[STAT_MODE_MSB:STAT_MODE_LSB] = mode;
                next_prdata[STAT_CARRIER_BIT] = carrier_sense;
                next_prdata[STAT_COLLISION_BIT] = collision;
                next_prdata[STAT_HEARTBEAT_BIT] = hb_busy;
                next_prdata[STAT_MODE_VALID_BIT] = mode_valid;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '{full_duplex: CTRL_FULL_DUPLEX_RST, speed_100: CTRL_SPEED_100_RST,
                      heartbeat_en: CTRL_HEARTBEAT_RST};
            prdata <= '0;
        end else begin
            ctrl <= next_ctrl;
            prdata <= next_prdata;
        end
    end

    // Heartbeat after transmit end
    logic tx_prev;
    logic hb_start;

    assign hb_start = tx_prev && !pin_sync.tx_en && mode == MODE_MII && !ctrl.full_duplex
                      && !ctrl.speed_100 && ctrl.heartbeat_en;

    heartbeat_timer u_heartbeat (
        .pclk(pclk),
        .presetn(presetn),
        .start(hb_start),
        .busy(hb_busy)
    );

    // Carrier, collision and clock output
    logic dv_phase;
    logic next_dv_phase;
    logic next_crs;
    logic next_col;
    logic overlap;

    assign overlap = pin_sync.tx_en && medium_busy;

    always_comb begin
        next_crs = 1'b0;
        next_col = 1'b0;
        next_dv_phase = 1'b0;
        case (mode)
            MODE_MII: begin
                next_crs = medium_busy;
                next_col = !ctrl.full_duplex && (overlap || hb_busy);
            end
            MODE_RMII: begin
                next_dv_phase = !medium_busy && rx_data_valid && !dv_phase;
                next_crs = medium_busy || (rx_data_valid && dv_phase);
                next_col = 1'b0;
            end
            MODE_SNI: begin
                next_crs = medium_busy;
                next_col = !ctrl.full_duplex && overlap;
            end
            default: begin
                next_crs = 1'b0;
                next_col = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_prev <= 1'b0;
            dv_phase <= 1'b0;
            carrier_sense <= 1'b0;
            collision <= 1'b0;
            system_clock_output <= 1'b0;
        end else begin
            tx_prev <= pin_sync.tx_en;
            dv_phase <= next_dv_phase;
            carrier_sense <= next_crs;
            collision <= next_col;
            system_clock_output <= pin_sync.ref_clk;
        end
    end

    // Checks
    sequence s_hb_begin;
        hb_start ##1 (!ctrl.full_duplex && mode == MODE_MII);
    endsequence

    property p_mii_crs;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_MII && mode_valid) |=> (carrier_sense == $past(medium_busy));
    endproperty
    a_mii_crs: assert property (p_mii_crs) else $error("MII carrier wrong");

    property p_rmii_crs;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_RMII && medium_busy) |=> carrier_sense;
    endproperty
    a_rmii_crs: assert property (p_rmii_crs) else $error("RMII carrier lost");

    property p_rmii_idle;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_RMII && !medium_busy && !rx_data_valid) |=> !carrier_sense;
    endproperty
    a_rmii_idle: assert property (p_rmii_idle) else $error("RMII carrier while idle");

    property p_sni_crs;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_SNI && mode_valid) |=> (carrier_sense == $past(medium_busy));
    endproperty
    a_sni_crs: assert property (p_sni_crs) else $error("SNI carrier wrong");

    property p_mii_col;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_MII && !ctrl.full_duplex && overlap) |=> collision;
    endproperty
    a_mii_col: assert property (p_mii_col) else $error("MII collision missed");

    property p_heartbeat;
        @(posedge pclk) disable iff (!presetn)
        s_hb_begin |=> collision;
    endproperty
    a_heartbeat: assert property (p_heartbeat) else $error("Heartbeat missing");

    property p_hb_hold;
        @(posedge pclk) disable iff (!presetn)
        (hb_busy && mode == MODE_MII && !ctrl.full_duplex) |=> collision;
    endproperty
    a_hb_hold: assert property (p_hb_hold) else $error("Heartbeat cut short");

    property p_fd_quiet;
        @(posedge pclk) disable iff (!presetn)
        ctrl.full_duplex |=> !collision;
    endproperty
    a_fd_quiet: assert property (p_fd_quiet) else $error("Collision in full duplex");

    property p_rmii_nocol;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_RMII) |=> !collision;
    endproperty
    a_rmii_nocol: assert property (p_rmii_nocol) else $error("RMII collision driven");

    property p_sni_col;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_SNI && !ctrl.full_duplex && overlap) |=> collision;
    endproperty
    a_sni_col: assert property (p_sni_col) else $error("SNI collision missed");

    property p_sysclk;
        @(posedge pclk) disable iff (!presetn)
        mode_valid |-> (system_clock_output == $past(reference_clock_input, 3));
    endproperty
    a_sysclk: assert property (p_sysclk) else $error("Clock output lag wrong");

    property p_mode_stable;
        @(posedge pclk) disable iff (!presetn)
        mode_valid |=> (mode_valid && $stable(mode));
    endproperty
    a_mode_stable: assert property (p_mode_stable) else $error("Mode changed");

endmodule

// ==== testbench/mac_model.sv ====
`timescale 1ns/1ps
module mac_model (
    input wire logic pclk,
    input wire logic sel50,
    input wire logic tx_req,
    input wire logic carrier_sense,
    output logic reference_clock_input,
    output logic tx_enable,
    output logic mac_collision,
    output logic rx_bit_valid
);
    initial begin
        reference_clock_input = 1'b0;
        // Offset keeps reference edges off the sampling clock edges
        #1;
        forever begin
            #((sel50 === 1'b1) ? 10.0 : 20.0);
            reference_clock_input = ~reference_clock_input;
        end
    end
    initial tx_enable = 1'b0;
    always @(posedge pclk) tx_enable <= tx_req;
    assign mac_collision = sel50 & carrier_sense & tx_enable;
    assign rx_bit_valid = carrier_sense;
endmodule

// ==== testbench/phy_mac_side_carrier_collision_clock_tb.sv ====
`timescale 1ns/1ps
module phy_mac_side_carrier_collision_clock_tb
    import phy_status_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_req, tx_enable, refclk;
    logic medium_busy, rx_data_valid, strap_rmii, strap_sni, carrier_sense, collision, sys_clk;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err, mac_col;
    int n_errors, tests_run, cycles, c;

    phy_mac_status dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .medium_busy(medium_busy),
        .rx_data_valid(rx_data_valid), .tx_enable(tx_enable), .reference_clock_input(refclk),
        .strap_rmii(strap_rmii), .strap_sni(strap_sni), .carrier_sense(carrier_sense),
        .collision(collision), .system_clock_output(sys_clk));
    mac_model mac (.pclk(pclk), .sel50(strap_rmii), .tx_req(tx_req),
        .carrier_sense(carrier_sense), .reference_clock_input(refclk), .tx_enable(tx_enable),
        .mac_collision(mac_col), .rx_bit_valid());

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task test_done();
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task do_reset(input logic r, input logic s);
        presetn <= 1'b0;
        strap_rmii <= r;
        strap_sni <= s;
        medium_busy <= 1'b0;
        rx_data_valid <= 1'b0;
        tx_req <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    task count_col(input int n);
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (collision === 1'b1) c++;
        end
    endtask

    task t_mode(input logic [1:0] m, input int edges);
        logic prev;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("mode", 32'h20 | 32'(m), rd & 32'h23);
        c = 0;
        prev = sys_clk;
        repeat (200) begin
            @(posedge pclk);
            if (sys_clk === 1'b1 && prev === 1'b0) c++;
            prev = sys_clk;
        end
        chk("clock edges", 32'h1, 32'(c >= edges - 1 && c <= edges + 1));
    endtask

    task t_regs();
        logic [31:0] ctrl_rst;
        ctrl_rst = 32'({CTRL_HEARTBEAT_RST, CTRL_SPEED_100_RST, CTRL_FULL_DUPLEX_RST});
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", ctrl_rst, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, ADDR_CTRL, 32'hffff_fff9);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl write", 32'h1, rd);
    endtask

    task t_overlap(input logic [31:0] ctrl, input logic exp);
        apb(1'b1, ADDR_CTRL, ctrl);
        medium_busy <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("carrier busy", 32'h1, 32'(carrier_sense));
        tx_req <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("collision", 32'(exp), 32'(collision));
        tx_req <= 1'b0;
        medium_busy <= 1'b0;
        count_col(300);
        chk("collision tail", 32'(exp), 32'(c));
        repeat (3) @(posedge pclk);
        chk("carrier idle", 32'h0, 32'(carrier_sense));
    endtask

    task t_heartbeat(input logic [31:0] ctrl, input int exp);
        apb(1'b1, ADDR_CTRL, ctrl);
        tx_req <= 1'b1;
        repeat (10) @(posedge pclk);
        tx_req <= 1'b0;
        count_col(300);
        chk("heartbeat cycles", 32'(exp), 32'(c));
    endtask

    task t_rmii();
        medium_busy <= 1'b1;
        rx_data_valid <= 1'b1;
        tx_req <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("crs_dv busy", 32'h1, 32'(carrier_sense));
        chk("rmii collision", 32'h0, 32'(collision));
        chk("mac collision", 32'h1, 32'(mac_col));
        medium_busy <= 1'b0;
        repeat (3) @(posedge pclk);
        c = 32'(carrier_sense);
        @(posedge pclk);
        chk("crs_dv toggles", 32'h1, 32'(c) ^ 32'(carrier_sense));
        rx_data_valid <= 1'b0;
        tx_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("crs_dv idle", 32'h0, 32'(carrier_sense));
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        presetn = 1'b0;
        do_reset(1'b0, 1'b0);
        t_regs();
        t_mode(2'h0, 40);
        t_overlap(32'h6, 1'b1);
        t_overlap(32'h0, 1'b1);
        t_overlap(32'h5, 1'b0);
        t_heartbeat(32'h4, HEARTBEAT_CYCLES);
        t_heartbeat(32'h5, 0);
        t_heartbeat(32'h6, 0);
        do_reset(1'b1, 1'b0);
        t_mode(2'h1, 80);
        t_rmii();
        do_reset(1'b0, 1'b1);
        t_mode(2'h2, 40);
        t_overlap(32'h6, 1'b1);
        test_done();
    end
endmodule
